// ---- logic/fmls_unit.sv ----
`timescale 1ns/1ps
`include "fmls_map.svh"
module fmls_unit (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // instruction issue
  input wire logic issue_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [15:0] rsa_val_in,
  input wire logic [15:0] rsb_val_in,
  input wire fmls_pkg::fmls_srcregs_type src_regs_in,
  output logic issue_ack_out,
  // register access interlock
  input wire logic acc_valid_in,
  input wire logic [5:0] acc_reg_in,
  output logic acc_grant_out,
  // register file write port
  output logic rf_we_out,
  output logic [5:0] rf_waddr_out,
  output logic [15:0] rf_wdata_out,
  // linked writeback from alu
  input wire logic um_valid_in,
  input wire logic [5:0] um_reg_in,
  input wire logic [15:0] um_data_in,
  output logic um_ack_out,
  // crc holder capture
  input wire logic dma_crc_start_in,
  input wire logic dma_crc_sel_b_in,
  input wire logic [19:0] link_addr_in,
  // fast memory read
  output logic fm_rd_req_out,
  output logic [19:0] fm_rd_addr_out,
  input wire logic fm_rd_valid_in,
  input wire logic [15:0] fm_rd_data_in,
  // fast memory write
  output logic fm_wr_valid_out,
  output fmls_pkg::fmls_wentry_type fm_wr_entry_out,
  input wire logic fm_wr_ready_in,
  // status
  output logic burst_busy_out,
  output logic link_active_out,
  output logic wbuf_full_out
);
  fmls_pkg::fmls_burst_state_type state_q, state_d;
  logic [5:0] rd_q;
  logic [4:0] cnt_q;
  logic [4:0] fetch_left_q;
  logic [19:0] fetch_addr_q;
  logic [4:0] fill_idx_q;
  logic [15:0] pending_q;
  logic [2:0] base_wait_q;
  logic base_seen_q;
  logic link_valid_q;
  logic [19:0] link_base_q;
  logic [19:0] hold_a_q;
  logic [19:0] hold_b_q;
  logic [2:0] wb_wptr_q;
  logic [2:0] wb_rptr_q;
  logic out_valid_q;

  // instruction decode
  wire [5:0] opc = instr_in[`FMLS_OPC_HI:`FMLS_OPC_LO];
  wire is_burst = opc == `FMLS_OPC_BURST;
  wire is_store = opc == `FMLS_OPC_STORE;
  wire [5:0] f_rd = instr_in[`FMLS_RD_HI:`FMLS_RD_LO];
  wire f_lnk = instr_in[`FMLS_LNK_BIT];
  wire [1:0] f_adr = instr_in[`FMLS_ADR_HI:`FMLS_ADR_LO];
  wire [2:0] f_reg = instr_in[`FMLS_REG_HI:`FMLS_REG_LO];
  wire [4:0] f_hw_raw = instr_in[`FMLS_HW_HI:`FMLS_HW_LO];
  wire [4:0] f_lsbs = instr_in[`FMLS_LSBS_HI:`FMLS_LSBS_LO];
  // lengths above sixteen are illegal; capping keeps the scoreboard bounded
  wire [4:0] f_hw = (f_hw_raw > `FMLS_HW_MAX) ? `FMLS_HW_MAX : f_hw_raw;
  wire [19:0] base_addr = {rsa_val_in[3:0], rsb_val_in};

  // write buffer occupancy, output stage counted as an entry
  wire [2:0] wb_cnt = wb_wptr_q - wb_rptr_q;
  wire [2:0] wb_occ = wb_cnt + {2'h0, out_valid_q};
  wire wb_full = wb_occ >= `FMLS_WB_DEPTH;

  // issue acceptance; the cycle after an ack is skipped since valid is still up
  wire issue_open = issue_valid_in & ~issue_ack_out;
  wire take_burst = issue_open & is_burst & (state_q == fmls_pkg::BURST_IDLE);
  wire take_store = issue_open & is_store & ~wb_full;
  wire take_other = issue_open & ~is_burst & ~is_store;
  wire issue_ack_d = take_burst | take_store | take_other;

  // store address selection
  wire [19:0] hi_src = (f_adr == `FMLS_ADR_HOLD_A) ? hold_a_q :
                       (f_adr == `FMLS_ADR_HOLD_B) ? hold_b_q : base_addr;
  wire [19:0] subst_addr = {hi_src[19:5], f_lsbs};
  wire [19:0] st_addr = (f_adr == `FMLS_ADR_COMPAT) ? base_addr : subst_addr;

  // store source selection
  // codes one to three pick the hardware registers; index kept in range for every code
  wire [15:0] hw_pick = (f_reg[1:0] == 2'h1) ? src_regs_in.hw[0] :
                        (f_reg[1:0] == 2'h2) ? src_regs_in.hw[1] : src_regs_in.hw[2];
  wire [15:0] crc_pick = src_regs_in.crc_part[f_reg[1:0]];
  wire [15:0] st_data = (f_reg == `FMLS_REG_DATA) ? src_regs_in.data_reg :
                        f_reg[2] ? crc_pick : hw_pick;

  // scoreboard lookup for a core access
  wire [5:0] acc_off = acc_reg_in - rd_q;
  wire acc_in_win = (acc_off[5:4] == 2'h0) & ({1'b0, acc_off[3:0]} < cnt_q);
  wire acc_is_base = acc_off == 6'h00;
  wire upper_group = rd_q[5:4] == 2'h1;
  wire base_block = (base_wait_q != 3'h0) | pending_q[0];
  // low-group later registers are not guarded; ordering is up to the code
  wire later_block = upper_group &
                     (pending_q[acc_off[3:0]] | (~base_seen_q & (|pending_q)));
  wire acc_blocked = acc_in_win & (acc_is_base ? base_block : later_block);
  wire take_acc = acc_valid_in & ~acc_grant_out & ~acc_blocked;

  // linked writeback address
  wire [5:0] um_off = um_reg_in - rd_q;
  wire um_hit = link_valid_q & (um_off[5:4] == 2'h0) & ({1'b0, um_off[3:0]} < cnt_q);
  wire [19:0] um_addr = link_base_q + {15'h0000, um_off[3:0], 1'b0};
  wire take_um = um_valid_in & ~um_ack_out & ~take_store & ~wb_full;

  // buffer push and pop
  wire push = take_store | (take_um & um_hit);
  fmls_pkg::fmls_wentry_type push_entry;
  assign push_entry.addr = take_store ? st_addr : um_addr;
  assign push_entry.data = take_store ? st_data : um_data_in;
  wire pop = (wb_cnt != 3'h0) & (~out_valid_q | fm_wr_ready_in);
  wire out_valid_d = pop | (out_valid_q & ~fm_wr_ready_in);
  // occupancy after this edge, so the status flag lines up with the stall
  wire [2:0] wb_occ_next = wb_occ + {2'h0, push} - {2'h0, fm_wr_ready_in & out_valid_q};

  // burst fill
  wire fill_hit = fm_rd_valid_in & pending_q[fill_idx_q[3:0]];
  wire fetch_last = fetch_left_q == 5'h01;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fmls_pkg::BURST_IDLE: begin
        if (take_burst && f_hw != 5'h00) begin
          state_d = fmls_pkg::BURST_FETCH;
        end
      end
      fmls_pkg::BURST_FETCH: begin
        if (fetch_last) begin
          state_d = fmls_pkg::BURST_FILL;
        end
      end
      fmls_pkg::BURST_FILL: begin
        if (pending_q == 16'h0000) begin
          state_d = fmls_pkg::BURST_IDLE;
        end
      end
      default: begin
        state_d = fmls_pkg::BURST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_q <= fmls_pkg::BURST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // burst context
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rd_q <= 6'h00;
      cnt_q <= 5'h00;
      link_valid_q <= 1'b0;
      link_base_q <= `FMLS_ADDR_RST;
    end else if (take_burst) begin
      rd_q <= f_rd;
      cnt_q <= f_hw;
      link_valid_q <= f_lnk;
      link_base_q <= base_addr;
    end
  end

  // fetch sequencer: one read request per cycle, ascending addresses
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      fetch_left_q <= 5'h00;
      fetch_addr_q <= `FMLS_ADDR_RST;
    end else if (take_burst) begin
      fetch_left_q <= f_hw;
      fetch_addr_q <= base_addr;
    end else if (state_q == fmls_pkg::BURST_FETCH) begin
      fetch_left_q <= fetch_left_q - 5'h01;
      fetch_addr_q <= fetch_addr_q + 20'h0_0002;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      fm_rd_req_out <= 1'b0;
      fm_rd_addr_out <= `FMLS_ADDR_RST;
    end else begin
      fm_rd_req_out <= state_q == fmls_pkg::BURST_FETCH;
      fm_rd_addr_out <= fetch_addr_q;
    end
  end

  // returned data go to rd, rd+1, ... in arrival order
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rf_we_out <= 1'b0;
      rf_waddr_out <= 6'h00;
      rf_wdata_out <= 16'h0000;
    end else begin
      rf_we_out <= fill_hit;
      rf_waddr_out <= rd_q + {2'h0, fill_idx_q[3:0]};
      rf_wdata_out <= fm_rd_data_in;
    end
  end

  // index only moves on a hit, so stray returns cannot skip a register
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      fill_idx_q <= 5'h00;
    end else if (take_burst) begin
      fill_idx_q <= 5'h00;
    end else if (fill_hit) begin
      fill_idx_q <= fill_idx_q + 5'h01;
    end
  end

  // scoreboard: one bit per destination offset
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pend
      always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
          pending_q[gi] <= 1'b0;
        end else if (take_burst) begin
          pending_q[gi] <= gi < f_hw;
        end else if (fill_hit && fill_idx_q[3:0] == gi) begin
          pending_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // base register hold-off
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      base_wait_q <= 3'h0;
    end else if (take_burst && f_hw != 5'h00) begin
      base_wait_q <= `FMLS_BASE_WAIT;
    end else if (base_wait_q != 3'h0) begin
      base_wait_q <= base_wait_q - 3'h1;
    end
  end

  // a new burst forgets any earlier base access
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      base_seen_q <= 1'b0;
    end else if (take_burst) begin
      base_seen_q <= 1'b0;
    end else if (take_acc && acc_is_base) begin
      base_seen_q <= 1'b1;
    end
  end

  // handshake pulses, one cycle each
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      issue_ack_out <= 1'b0;
    end else begin
      issue_ack_out <= issue_ack_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      acc_grant_out <= 1'b0;
    end else begin
      acc_grant_out <= take_acc;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      um_ack_out <= 1'b0;
    end else begin
      um_ack_out <= take_um;
    end
  end

  // crc holders capture the link address as the dma starts
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      hold_a_q <= `FMLS_ADDR_RST;
      hold_b_q <= `FMLS_ADDR_RST;
    end else if (dma_crc_start_in) begin
      if (dma_crc_sel_b_in) begin
        hold_b_q <= link_addr_in;
      end else begin
        hold_a_q <= link_addr_in;
      end
    end
  end

  // write buffer pointers and output stage
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wb_wptr_q <= 3'h0;
    end else if (push) begin
      wb_wptr_q <= wb_wptr_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wb_rptr_q <= 3'h0;
    end else if (pop) begin
      wb_rptr_q <= wb_rptr_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= out_valid_d;
    end
  end

  // read data register of the buffer memory is the write port itself
  fmls_wbuf_mem u_wbuf (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .we_in(push),
    .waddr_in(wb_wptr_q[1:0]),
    .wdata_in(push_entry),
    .re_in(pop),
    .raddr_in(wb_rptr_q[1:0]),
    .rdata_out(fm_wr_entry_out)
  );

  assign fm_wr_valid_out = out_valid_q;
  assign link_active_out = link_valid_q;

  // status, registered from next-state values so it lines up with the internal state
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      burst_busy_out <= 1'b0;
      wbuf_full_out <= 1'b0;
    end else begin
      burst_busy_out <= state_d != fmls_pkg::BURST_IDLE;
      wbuf_full_out <= wb_occ_next >= `FMLS_WB_DEPTH;
    end
  end
endmodule : fmls_unit

// ---- logic/fmls_map.svh ----
// Functional notes
// - compatibility address mode ignores low-bit field
// - other modes substitute address bits four..zero
// - burst load fetches halfwords from rsa/rsb address
// - destination registers written base first, ascending
// - base register access stalls four cycles after burst
// - upper group: scoreboard guards later destination registers
// - core stalls on register still being loaded; code stalls the base in any group, later registers only in upper group
// - later registers guaranteed only after base accessed
// - link records structure for later writeback copies
// - data-register store writes halfword at rsa/rsb
// - stores enter write buffer, core keeps running
// - store stalls while four buffer entries occupied
// - selected store: register source, alternate address
// - crc pair stored at holder base plus offset
// - mode zero and select zero equal data store
// - address mode encoding: base, substitute, holder a/b
// - select code: data, three hardware, four crc
// - dma crc start copies link address into holder
`ifndef FMLS_MAP_SVH
`define FMLS_MAP_SVH
`define FMLS_OPC_HI 31
`define FMLS_OPC_LO 26
`define FMLS_OPC_BURST 6'h15
`define FMLS_OPC_STORE 6'h17
`define FMLS_RD_HI 25
`define FMLS_RD_LO 20
`define FMLS_LNK_BIT 19
`define FMLS_ADR_HI 20
`define FMLS_ADR_LO 19
`define FMLS_REG_HI 18
`define FMLS_REG_LO 16
`define FMLS_HW_HI 9
`define FMLS_HW_LO 5
`define FMLS_LSBS_HI 9
`define FMLS_LSBS_LO 5
`define FMLS_ADR_COMPAT 2'h0
`define FMLS_ADR_SUBST 2'h1
`define FMLS_ADR_HOLD_A 2'h2
`define FMLS_ADR_HOLD_B 2'h3
`define FMLS_REG_DATA 3'h0
`define FMLS_HW_MAX 5'h10
`define FMLS_WB_DEPTH 3'h4
`define FMLS_BASE_WAIT 3'h4
`define FMLS_ADDR_RST 20'h0_0000
`endif

// ---- logic/fmls_pkg.sv ----
package fmls_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fmls_wentry_type;

  typedef struct packed {
    logic [15:0] data_reg;
    logic [2:0][15:0] hw;
    logic [3:0][15:0] crc_part;
  } fmls_srcregs_type;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_FETCH,
    BURST_FILL
  } fmls_burst_state_type;
endpackage : fmls_pkg

// ---- logic/fmls_wbuf_mem.sv ----
`timescale 1ns/1ps
module fmls_wbuf_mem (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // write side
  input wire logic we_in,
  input wire logic [1:0] waddr_in,
  input wire fmls_pkg::fmls_wentry_type wdata_in,
  // read side
  input wire logic re_in,
  input wire logic [1:0] raddr_in,
  output fmls_pkg::fmls_wentry_type rdata_out
);
  fmls_pkg::fmls_wentry_type mem_q [4];

  // array has no reset: entries are only read after being written
  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (re_in) begin
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule : fmls_wbuf_mem

// ---- tb/fmls_unit_checker.sv ----
`timescale 1ns/1ps
module fmls_unit_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // issue and interlock
  input wire logic issue_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic issue_ack_out,
  input wire logic acc_valid_in,
  input wire logic acc_grant_out,
  input wire logic rf_we_out,
  // fast memory
  input wire logic fm_rd_valid_in,
  input wire logic fm_rd_req_out,
  input wire logic [19:0] fm_rd_addr_out,
  input wire logic fm_wr_valid_out,
  input wire fmls_pkg::fmls_wentry_type fm_wr_entry_out,
  input wire logic fm_wr_ready_in,
  input wire logic wbuf_full_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_ack_single: assert property (issue_ack_out |=> !issue_ack_out)
    else $error("issue ack longer than one cycle");
  a_ack_cause: assert property (issue_ack_out |-> $past(issue_valid_in))
    else $error("issue ack without request");
  a_grant_cause: assert property (acc_grant_out |-> $past(acc_valid_in))
    else $error("grant without access request");
  a_rf_from_data: assert property (rf_we_out |-> $past(fm_rd_valid_in))
    else $error("register write without returned data");
  a_wr_hold: assert property (fm_wr_valid_out && !fm_wr_ready_in
    |=> fm_wr_valid_out && $stable(fm_wr_entry_out))
    else $error("write entry changed before acceptance");
  a_full_blocks: assert property (wbuf_full_out && issue_valid_in && !issue_ack_out
    && instr_in[31:26] == 6'h17 |=> !issue_ack_out)
    else $error("store taken while buffer full");
  a_rd_addr_step: assert property (fm_rd_req_out && $past(fm_rd_req_out)
    |-> fm_rd_addr_out == $past(fm_rd_addr_out) + 20'h0_0002)
    else $error("burst read address not ascending by two");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_in
    |=> !issue_ack_out && !fm_wr_valid_out && !rf_we_out)
    else $error("output active after reset");
  c_burst: cover property (fm_rd_req_out);
  c_full: cover property (wbuf_full_out);
  c_grant: cover property (acc_grant_out);
endmodule : fmls_unit_checker

bind fmls_unit fmls_unit_checker u_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .issue_valid_in(issue_valid_in), .instr_in(instr_in), .issue_ack_out(issue_ack_out),
  .acc_valid_in(acc_valid_in), .acc_grant_out(acc_grant_out), .rf_we_out(rf_we_out),
  .fm_rd_valid_in(fm_rd_valid_in), .fm_rd_req_out(fm_rd_req_out),
  .fm_rd_addr_out(fm_rd_addr_out), .fm_wr_valid_out(fm_wr_valid_out),
  .fm_wr_entry_out(fm_wr_entry_out), .fm_wr_ready_in(fm_wr_ready_in),
  .wbuf_full_out(wbuf_full_out));

// ---- tb/fmls_fm_model.sv ----
`timescale 1ns/1ps
module fmls_fm_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // read side
  input wire logic fast_in,
  input wire logic rd_req_in,
  input wire logic [19:0] rd_addr_in,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  // write side
  input wire logic hold_wr_in,
  output logic wr_ready_out
);
  logic [2:0] v_q;
  logic [2:0][19:0] a_q;
  logic [15:0] junk_q;
  always_ff @(posedge core_clk_in) begin
    v_q <= nrst_in ? {v_q[1:0], rd_req_in} : 3'h0;
    a_q <= {a_q[1:0], rd_addr_in};
    junk_q <= nrst_in ? junk_q + 16'h37B1 : 16'hC0DE;
  end
  // answers in request order, one or three cycles late
  assign rd_valid_out = fast_in ? v_q[0] : v_q[2];
  // idle data churns so a stale sample never matches
  assign rd_data_out = rd_valid_out ? (a_q[fast_in ? 0 : 2][15:0] ^ 16'h5A5A) : junk_q;
  assign wr_ready_out = !hold_wr_in;
endmodule : fmls_fm_model

// ---- tb/fmls_unit_tb_top.sv ----
`timescale 1ns/1ps
`include "fmls_map.svh"
module fmls_unit_tb_top;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic issue_valid_in = 1'b0;
  logic [31:0] instr_in = 32'h0000_0000;
  logic [15:0] rsa_val_in = 16'h0000;
  logic [15:0] rsb_val_in = 16'h0000;
  fmls_pkg::fmls_srcregs_type src_regs_in = {16'h1111, 16'h2003, 16'h2002, 16'h2001,
    16'h4003, 16'h4002, 16'h4001, 16'h4000};
  logic acc_valid_in = 1'b0;
  logic [5:0] acc_reg_in = 6'h00;
  logic um_valid_in = 1'b0;
  logic [5:0] um_reg_in = 6'h00;
  logic [15:0] um_data_in = 16'h0000;
  logic dma_crc_start_in = 1'b0;
  logic dma_crc_sel_b_in = 1'b0;
  logic [19:0] link_addr_in = 20'h0_0000;
  logic hold_wr = 1'b0;
  logic fast_rd = 1'b0;
  logic issue_ack_out, acc_grant_out, rf_we_out, um_ack_out, fm_rd_req_out, fm_rd_valid_in;
  logic fm_wr_valid_out, fm_wr_ready_in, burst_busy_out, link_active_out, wbuf_full_out;
  logic [5:0] rf_waddr_out;
  logic [15:0] rf_wdata_out, fm_rd_data_in;
  logic [19:0] fm_rd_addr_out;
  fmls_pkg::fmls_wentry_type fm_wr_entry_out;
  fmls_pkg::fmls_wentry_type wq[$];
  logic [21:0] rq[$];
  int miscompares = 0;
  int n_compared = 0;

  always #25 core_clk_in = ~core_clk_in;

  fmls_unit u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .issue_valid_in(issue_valid_in), .instr_in(instr_in), .rsa_val_in(rsa_val_in),
    .rsb_val_in(rsb_val_in), .src_regs_in(src_regs_in), .issue_ack_out(issue_ack_out),
    .acc_valid_in(acc_valid_in), .acc_reg_in(acc_reg_in), .acc_grant_out(acc_grant_out),
    .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out), .rf_wdata_out(rf_wdata_out),
    .um_valid_in(um_valid_in), .um_reg_in(um_reg_in), .um_data_in(um_data_in),
    .um_ack_out(um_ack_out), .dma_crc_start_in(dma_crc_start_in),
    .dma_crc_sel_b_in(dma_crc_sel_b_in), .link_addr_in(link_addr_in),
    .fm_rd_req_out(fm_rd_req_out), .fm_rd_addr_out(fm_rd_addr_out),
    .fm_rd_valid_in(fm_rd_valid_in), .fm_rd_data_in(fm_rd_data_in),
    .fm_wr_valid_out(fm_wr_valid_out), .fm_wr_entry_out(fm_wr_entry_out),
    .fm_wr_ready_in(fm_wr_ready_in), .burst_busy_out(burst_busy_out),
    .link_active_out(link_active_out), .wbuf_full_out(wbuf_full_out));

  fmls_fm_model u_fm (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .fast_in(fast_rd),
    .rd_req_in(fm_rd_req_out), .rd_addr_in(fm_rd_addr_out), .rd_valid_out(fm_rd_valid_in),
    .rd_data_out(fm_rd_data_in), .hold_wr_in(hold_wr), .wr_ready_out(fm_wr_ready_in));

  always @(posedge core_clk_in) begin
    if (fm_wr_valid_out && fm_wr_ready_in) wq.push_back(fm_wr_entry_out);
    if (rf_we_out) rq.push_back({rf_waddr_out, rf_wdata_out});
  end

  function automatic logic [31:0] st(input logic [1:0] adr, input logic [2:0] sel,
                                     input logic [4:0] ls);
    return {`FMLS_OPC_STORE, 5'h00, adr, sel, 6'h00, ls, 5'h00};
  endfunction : st

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // short waits are deliberate stall probes, long ones end the run if used up
  task automatic wait_hi(ref logic s, input int n, output logic got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge core_clk_in);
      #1;
      got = s;
    end
    if (!got && n > 10) begin
      chk(40'h0, 40'h1);
      wrap_up;
    end
  endtask : wait_hi

  task automatic drain(input int n, input logic rfq);
    for (int i = 0; i < 60 && (rfq ? rq.size() : wq.size()) < n; i++) @(posedge core_clk_in);
    chk(40'(rfq ? rq.size() : wq.size()), 40'(n));
    if ((rfq ? rq.size() : wq.size()) < n) wrap_up;
  endtask : drain

  task automatic issue(input logic [31:0] ins, input logic [15:0] b, input int n,
                       output logic got);
    @(posedge core_clk_in);
    issue_valid_in <= 1'b1;
    instr_in <= ins;
    rsb_val_in <= b;
    wait_hi(issue_ack_out, n, got);
    if (got) begin
      @(posedge core_clk_in);
      issue_valid_in <= 1'b0;
    end
  endtask : issue

  task automatic access(input logic [5:0] r);
    logic g;
    @(posedge core_clk_in);
    acc_valid_in <= 1'b1;
    acc_reg_in <= r;
    wait_hi(acc_grant_out, 60, g);
    @(posedge core_clk_in);
    acc_valid_in <= 1'b0;
  endtask : access

  task automatic um(input logic [5:0] r, input logic [15:0] d);
    logic g;
    @(posedge core_clk_in);
    um_valid_in <= 1'b1;
    um_reg_in <= r;
    um_data_in <= d;
    wait_hi(um_ack_out, 40, g);
    @(posedge core_clk_in);
    um_valid_in <= 1'b0;
  endtask : um

  task automatic t_stores;
    logic g;
    logic [19:0] ea;
    wq.delete();
    @(posedge core_clk_in);
    rsa_val_in <= 16'h000A;
    dma_crc_start_in <= 1'b1;
    link_addr_in <= 20'h4_2340;
    @(posedge core_clk_in);
    dma_crc_sel_b_in <= 1'b1;
    link_addr_in <= 20'h8_1100;
    @(posedge core_clk_in);
    dma_crc_start_in <= 1'b0;
    issue(32'h0000_0000, 16'hBCD6, 40, g);
    for (int i = 0; i < 8; i++) issue(st(2'(i), 3'(i), 5'(3 * i + 1)), 16'hBCD6, 40, g);
    drain(8, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ea = i % 4 == 1 ? 20'hA_BCC0 : i % 4 == 2 ? 20'h4_2340 : 20'h8_1100;
      ea[4:0] = 5'(3 * i + 1);
      if (i % 4 == 0) ea = 20'hA_BCD6;
      chk(40'(wq[i].addr), 40'(ea));
      chk(40'(wq[i].data), i == 0 ? 40'h1111 : i < 4 ? 40'(16'h2000 + i) : 40'(16'h3FFC + i));
    end
    $display("stores done");
  endtask : t_stores

  task automatic t_full;
    logic g;
    wq.delete();
    @(posedge core_clk_in);
    rsa_val_in <= 16'h0001;
    hold_wr <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      issue(st(2'h0, 3'h0, 5'h00), 16'(2 * i), 3, g);
      chk(40'(g), 40'h1);
    end
    issue(st(2'h0, 3'h0, 5'h00), 16'h0008, 8, g);
    chk(40'({g, wbuf_full_out}), 40'h1);
    @(posedge core_clk_in);
    hold_wr <= 1'b0;
    wait_hi(issue_ack_out, 40, g);
    @(posedge core_clk_in);
    issue_valid_in <= 1'b0;
    drain(5, 1'b0);
    for (int i = 0; i < 5; i++) chk(40'(wq[i].addr), 40'(20'h1_0000 + 2 * i));
    $display("full buffer done");
  endtask : t_full

  // fast memory isolates the base wait, slow memory exercises the scoreboard
  task automatic t_burst(input logic fast);
    logic g;
    time t0;
    rq.delete();
    @(posedge core_clk_in);
    fast_rd <= fast;
    rsa_val_in <= 16'h0003;
    issue({`FMLS_OPC_BURST, 6'd16, !fast, 9'h000, 5'h04, 5'h00}, 16'h2040, 40, g);
    t0 = $time;
    chk(40'(burst_busy_out), 40'h1);
    access(fast ? 6'd16 : 6'd17);
    if (fast) chk(40'($time - t0), 40'hFA);
    chk(40'(rq.size() >= (fast ? 1 : 4)), 40'h1);
    drain(4, 1'b1);
    for (int i = 0; i < 4; i++) chk(40'(rq[i]), 40'({6'(16 + i), 16'(16'h2040 + 2 * i) ^ 16'h5A5A}));
    if (!fast) begin
      wq.delete();
      um(6'd18, 16'hBEEF);
      um(6'd40, 16'h1234);
      drain(1, 1'b0);
      repeat (10) @(posedge core_clk_in);
      chk({wq.size() == 1, 3'h0, wq[0]}, {4'h8, 20'h3_2044, 16'hBEEF});
    end
    repeat (4) @(posedge core_clk_in);
    chk(40'({burst_busy_out, link_active_out}), 40'(!fast));
    $display("burst done");
  endtask : t_burst

  initial begin
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    t_stores;
    t_full;
    t_burst(1'b1);
    t_burst(1'b0);
    wrap_up;
  end
endmodule : fmls_unit_tb_top
